// ### prlc_cfg.svh
// Constants for the PWM run, load and counter-clear control block.
`ifndef PRLC_CFG_SVH
`define PRLC_CFG_SVH

`define PRLC_AW           8
`define PRLC_DW           8
`define PRLC_CW           16
`define PRLC_CH           6
`define PRLC_SELW         3
`define PRLC_NEV          4

`define PRLC_ADDR_CTRL    8'hd7
`define PRLC_ADDR_MASK    8'hd8
`define PRLC_ADDR_STAT    8'hd9

`define PRLC_CTRL_RST     8'h00
`define PRLC_MASK_RST     4'h0
`define PRLC_STAT_RST     4'h0
`define PRLC_CNT_ZERO     16'h0000
`define PRLC_CNT_ONE      16'h0001
`define PRLC_RD_ZERO      8'h00
`define PRLC_ALL_ONES     8'hff
`define PRLC_BIT_ONE      8'h01

`define PRLC_B_RUN        7
`define PRLC_B_LOAD       6
`define PRLC_B_FLAG       5
`define PRLC_B_CLR        4

`define PRLC_EV_LOAD      0
`define PRLC_EV_CLR       1
`define PRLC_EV_FLAG      2
`define PRLC_EV_BRAKE     3

`endif

// ### prlc_pkg.sv
// Types shared by the PWM run, load and counter-clear control block.
`include "prlc_cfg.svh"
`default_nettype none

package prlc_pkg;

  typedef enum logic [1:0] {
    PRLC_PT_FALL,
    PRLC_PT_RISE,
    PRLC_PT_CENTER,
    PRLC_PT_END
  } prlc_point_e;

  typedef logic [`PRLC_CW-1:0] prlc_cnt_t;

  typedef struct packed {
    logic                          run;
    logic                          load_pend;
    logic                          flag;
    logic                          clr_pend;
    prlc_cnt_t                     cnt;
    prlc_cnt_t                     period;
    logic [`PRLC_CH-1:0][`PRLC_CW-1:0] duty;
    logic [`PRLC_CH-1:0]           pg;
    logic                          period_end;
    logic [`PRLC_NEV-1:0]          mask;
    logic [`PRLC_NEV-1:0]          stat;
    logic [`PRLC_DW-1:0]           rdata;
  } prlc_state_s;

endpackage

`default_nettype wire

// ### prlc_ctrl.sv
// Run, buffered load, period-point flag and counter clear of a PWM unit.
//
// Behaviour
// - Run enable bit 7: 0 holds generator idle, 1 counts and drives waveforms.
// - Writing 1 to bit 6 arms period and duty load at period end.
// - Loaded period and duty apply from the next PWM cycle onward.
// - Load bit reads 1 while pending, hardware clears it after transfer.
// - Flag bit 5 set at selected channel and point; software clears it.
// - Writing 1 to bit 4 zeroes the 16-bit counter; 0 does nothing.
// - Clear bit reads 1 until counter zeroed, then hardware clears it.
// - Control register at D7H, bit-writable, resets to all zeros.
// - Fault brake clears run enable until software sets it again.
//
// Our own choice: the address-and-strobe port.
`include "prlc_cfg.svh"
`default_nettype none

module prlc_ctrl (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Register port.
  input  wire logic [`PRLC_AW-1:0]         addr,
  input  wire logic [`PRLC_DW-1:0]         wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [`PRLC_DW-1:0]         rdata,
  // Single-bit write at addr.
  input  wire logic                        bit_wr,
  input  wire logic [2:0]                  bit_sel,
  input  wire logic                        bit_val,
  // Staged period and duty from the period and duty registers.
  input  wire logic [`PRLC_CW-1:0]         period_in,
  input  wire logic [`PRLC_CH*`PRLC_CW-1:0] duty_in,
  // Flag point selection and fault brake.
  input  wire logic [`PRLC_SELW-1:0]       flag_channel_select,
  input  wire logic [1:0]                  flag_point_type,
  input  wire logic                        fault_brake,
  // Generator state.
  output logic                             generator_run_enable,
  output logic                             period_point_flag,
  output logic      [`PRLC_CW-1:0]         counter,
  output logic      [`PRLC_CW-1:0]         period_buf,
  output logic      [`PRLC_CH*`PRLC_CW-1:0] duty_buf,
  output logic      [`PRLC_CH-1:0]         pg,
  output logic                             period_end,
  // Interrupt.
  output logic                             irq
);

  prlc_pkg::prlc_state_s q;
  prlc_pkg::prlc_state_s d;

  logic [`PRLC_DW-1:0]  wmask;
  logic [`PRLC_DW-1:0]  wval;
  logic                 ctrl_wr;
  logic                 ev_load;
  logic                 ev_clr;
  logic                 ev_flag;
  logic                 ev_brake;
  logic                 wrap;
  logic                 pt_hit;
  logic                 sel_ok;
  logic [`PRLC_NEV-1:0] ev;
  logic [`PRLC_DW-1:0]  ctrl_rd;
  prlc_pkg::prlc_point_e pt;

  always_comb begin
    d        = q;
    wmask    = '0;
    wval     = '0;
    ev_load  = 1'b0;
    ev_clr   = 1'b0;
    ev_flag  = 1'b0;
    ev_brake = 1'b0;
    pt_hit   = 1'b0;
    pt       = prlc_pkg::prlc_point_e'(flag_point_type);
    sel_ok   = 32'(flag_channel_select) < `PRLC_CH;

    // Byte write and single-bit write share one masked path.
    ctrl_wr = (wr || bit_wr) && (addr == `PRLC_ADDR_CTRL);
    if (wr) begin
      wmask = `PRLC_ALL_ONES;
      wval  = wdata;
    end else if (bit_wr) begin
      wmask = `PRLC_BIT_ONE << bit_sel;
      wval  = {`PRLC_DW{bit_val}};
    end

    // Counter advances only while running; wrap marks period end.
    wrap = q.run && (q.cnt == q.period);
    if (q.run) begin
      if (wrap) begin
        d.cnt = `PRLC_CNT_ZERO;
      end else begin
        d.cnt = q.cnt + `PRLC_CNT_ONE;
      end
    end
    d.period_end = wrap;

    // Pending load completes at the wrap, so the new values start
    // the cycle that begins at count zero.
    if (q.load_pend && wrap) begin
      d.period    = period_in;
      d.duty      = duty_in;
      d.load_pend = 1'b0;
      ev_load     = 1'b1;
    end

    // A pending clear zeroes the counter one edge after the write.
    if (q.clr_pend) begin
      d.cnt      = `PRLC_CNT_ZERO;
      d.clr_pend = 1'b0;
      ev_clr     = 1'b1;
    end

    // Software writes to the control bits; bits 3..0 have no storage.
    if (ctrl_wr) begin
      if (wmask[`PRLC_B_RUN]) begin
        d.run = wval[`PRLC_B_RUN];
      end
      if (wmask[`PRLC_B_LOAD] && wval[`PRLC_B_LOAD]) begin
        d.load_pend = 1'b1;
      end
      if (wmask[`PRLC_B_FLAG]) begin
        d.flag = wval[`PRLC_B_FLAG];
      end
      if (wmask[`PRLC_B_CLR] && wval[`PRLC_B_CLR]) begin
        d.clr_pend = 1'b1;
      end
    end

    // Brake overrides a same-cycle software start for safety.
    if (fault_brake) begin
      d.run    = 1'b0;
      d.cnt    = `PRLC_CNT_ZERO;
      ev_brake = q.run;
    end

    // Waveforms follow the next count, so they stay aligned with it.
    for (int i = 0; i < `PRLC_CH; i++) begin
      d.pg[i] = d.run && (d.cnt < d.duty[i]);
    end

    // Period-point detection on the selected channel.
    if (sel_ok && q.run) begin
      unique case (pt)
        prlc_pkg::PRLC_PT_FALL: begin
          pt_hit = q.pg[flag_channel_select] && !d.pg[flag_channel_select];
        end
        prlc_pkg::PRLC_PT_RISE: begin
          pt_hit = !q.pg[flag_channel_select] && d.pg[flag_channel_select];
        end
        prlc_pkg::PRLC_PT_CENTER: begin
          pt_hit = q.cnt == (q.period >> 1);
        end
        prlc_pkg::PRLC_PT_END: begin
          pt_hit = wrap;
        end
      endcase
    end
    // A hardware set wins over a same-cycle software clear.
    if (pt_hit) begin
      d.flag  = 1'b1;
      ev_flag = 1'b1;
    end

    // Interrupt mask and sticky status; a read clears, an event wins.
    if (wr && (addr == `PRLC_ADDR_MASK)) begin
      d.mask = wdata[`PRLC_NEV-1:0];
    end
    if (rd && (addr == `PRLC_ADDR_STAT)) begin
      d.stat = `PRLC_STAT_RST;
    end
    ev                 = '0;
    ev[`PRLC_EV_LOAD]  = ev_load;
    ev[`PRLC_EV_CLR]   = ev_clr;
    ev[`PRLC_EV_FLAG]  = ev_flag;
    ev[`PRLC_EV_BRAKE] = ev_brake;
    d.stat             = d.stat | ev;

    // Read data from current state, valid the cycle after the strobe.
    ctrl_rd                = `PRLC_RD_ZERO;
    ctrl_rd[`PRLC_B_RUN]   = q.run;
    ctrl_rd[`PRLC_B_LOAD]  = q.load_pend;
    ctrl_rd[`PRLC_B_FLAG]  = q.flag;
    ctrl_rd[`PRLC_B_CLR]   = q.clr_pend;
    d.rdata                = `PRLC_RD_ZERO;
    if (rd) begin
      unique case (addr)
        `PRLC_ADDR_CTRL: begin
          d.rdata = ctrl_rd;
        end
        `PRLC_ADDR_MASK: begin
          d.rdata = {{(`PRLC_DW-`PRLC_NEV){1'b0}}, q.mask};
        end
        `PRLC_ADDR_STAT: begin
          d.rdata = {{(`PRLC_DW-`PRLC_NEV){1'b0}}, q.stat};
        end
        default: begin
          d.rdata = `PRLC_RD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata                = q.rdata;
  assign generator_run_enable = q.run;
  assign period_point_flag    = q.flag;
  assign counter              = q.cnt;
  assign period_buf           = q.period;
  assign duty_buf             = q.duty;
  assign pg                   = q.pg;
  assign period_end           = q.period_end;
  assign irq                  = |(q.stat & q.mask);

endmodule

`default_nettype wire

// ### prlc_ctrl_asserts.sv
// Port checks for the PWM run, load and counter-clear control block.
`include "prlc_cfg.svh"
`default_nettype none
module prlc_ctrl_asserts (
  // Clock, reset and register port.
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [`PRLC_AW-1:0] addr,
  input wire logic [`PRLC_DW-1:0] wdata,
  input wire logic                wr,
  input wire logic                rd,
  input wire logic                bit_wr,
  input wire logic [`PRLC_DW-1:0] rdata,
  // Generator side.
  input wire logic                fault_brake,
  input wire logic [`PRLC_CW-1:0] period_in,
  input wire logic                generator_run_enable,
  input wire logic [`PRLC_CW-1:0] counter,
  input wire logic [`PRLC_CW-1:0] period_buf,
  input wire logic [`PRLC_CH-1:0] pg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic ctl_wr = wr && addr == `PRLC_ADDR_CTRL;
  wire logic quiet = !wr && !bit_wr && !fault_brake;
  wire logic run = generator_run_enable;
  chk_idle_pg: assert property (!run [*2] |-> pg == '0)
    else $error("waveform active while idle");
  chk_idle_count: assert property (
    !run [*2] |-> $stable(counter) || counter == '0)
    else $error("counter moved while idle");
  chk_wrap_zero: assert property (
    run && counter == period_buf && quiet |=> counter == '0)
    else $error("counter missed period wrap");
  chk_brake_stop: assert property (
    fault_brake |=> !run && counter == '0)
    else $error("brake did not stop generator");
  chk_clear_zero: assert property (
    ctl_wr && wdata[`PRLC_B_CLR] |-> ##2 counter == '0)
    else $error("counter not cleared");
  chk_load_edge: assert property (
    period_buf != $past(period_buf) |-> $past(run) && counter == '0)
    else $error("period loaded off period end");
  chk_load_value: assert property (
    period_buf != $past(period_buf) |-> period_buf == $past(period_in))
    else $error("wrong period loaded");
  chk_low_zero: assert property (
    rd && addr == `PRLC_ADDR_CTRL |=> rdata[3:0] == 4'h0)
    else $error("unused bits read nonzero");
  chk_rdata_rest: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
  cover property (fault_brake && run);
  cover property (period_buf != $past(period_buf));
  cover property (ctl_wr && wdata[`PRLC_B_CLR] && run);
endmodule

bind prlc_ctrl prlc_ctrl_asserts u_chk (.clk, .rst_n, .addr, .wdata, .wr,
  .rd, .bit_wr, .rdata, .fault_brake, .period_in, .generator_run_enable,
  .counter, .period_buf, .pg);
`default_nettype wire

// ### prlc_ctrl_tb_top.sv
// Self-checking bench for the PWM run, load and counter-clear control block.
`include "prlc_cfg.svh"
`default_nettype none
module prlc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        bit_wr = 1'b0, bit_val = 1'b0, fault_brake = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0]  bit_sel = 3'h0, flag_channel_select = 3'h6;
  logic [1:0]  flag_point_type = 2'h3;
  logic [15:0] period_in = 16'h0000, counter, period_buf;
  logic [95:0] duty_in = 96'h0, duty_buf;
  logic [5:0]  pg;
  logic        generator_run_enable, period_point_flag, period_end, irq;
  int          err_count = 0, check_count = 0;
  always #50 clk = ~clk;
  prlc_ctrl u_dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .bit_wr,
    .bit_sel, .bit_val, .period_in, .duty_in, .flag_channel_select,
    .flag_point_type, .fault_brake, .generator_run_enable,
    .period_point_flag, .counter, .period_buf, .duty_buf, .pg,
    .period_end, .irq);
  task automatic chk(input string what, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic wr_bit(input logic [7:0] a, input logic [2:0] b,
                        input logic v);
    @(posedge clk);
    addr <= a;
    bit_sel <= b;
    bit_val <= v;
    bit_wr <= 1'b1;
    @(posedge clk);
    bit_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, exp);
    logic [7:0] v;
    rd_reg(a, v);
    chk(what, {8'h00, exp}, {8'h00, v});
  endtask
  // The clear lands after the new point type is in force, so a set seen
  // here always belongs to the type under test.
  task automatic flag_case(input logic [1:0] t);
    @(posedge clk);
    flag_channel_select <= 3'h0;
    flag_point_type <= t;
    wr_reg(8'hd7, 8'h80);
    #1;
    for (int i = 0; i < 300 && period_point_flag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("flag raised", 16'h0001, {15'h0, period_point_flag});
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Channel 6 never raises the flag, so early wraps leave it clear.
  initial begin
    logic [7:0] v;
    int         n;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ctrl reset", 8'hd7, 8'h00);
    rd_chk("mask reset", 8'hd8, 8'h00);
    wr_reg(8'hd7, 8'h0f);
    rd_chk("ctrl low bits", 8'hd7, 8'h00);
    @(posedge clk);
    period_in <= 16'h00c8;
    duty_in <= {6{16'h0002}};
    wr_reg(8'hd7, 8'h40);
    rd_chk("load pending", 8'hd7, 8'h40);
    // A load only completes at a period end, so the run must start.
    wr_bit(8'hd7, 3'h7, 1'b1);
    n = 0;
    do begin
      rd_reg(8'hd7, v);
      n++;
    end while (v[6] !== 1'b0 && n < 20);
    rd_chk("load done", 8'hd7, 8'h80);
    chk("period buffer", 16'h00c8, period_buf);
    chk("duty buffer", 16'h0002, duty_buf[95:80]);
    chk("run output", 16'h0001, {15'h0, generator_run_enable});
    wr_reg(8'hd8, 8'h01);
    @(posedge clk);
    #1 chk("irq raised", 16'h0001, {15'h0, irq});
    rd_chk("status load", 8'hd9, 8'h01);
    @(posedge clk);
    #1 chk("irq cleared", 16'h0000, {15'h0, irq});
    repeat (20) @(posedge clk);
    wr_reg(8'hd7, 8'h90);
    @(posedge clk);
    #1 chk("counter cleared", 16'h0000, counter);
    chk("waveforms at zero", 16'h003f, {10'h0, pg});
    rd_chk("clear done", 8'hd7, 8'h80);
    flag_case(2'h3);
    chk("end point count", 16'h0000, counter);
    chk("period end", 16'h0001, {15'h0, period_end});
    rd_chk("flag set", 8'hd7, 8'ha0);
    wr_reg(8'hd7, 8'h80);
    rd_chk("flag cleared", 8'hd7, 8'h80);
    flag_case(2'h0);
    chk("fall point count", 16'h0002, counter);
    flag_case(2'h1);
    chk("rise point count", 16'h0000, counter);
    flag_case(2'h2);
    chk("center point count", 16'h0065, counter);
    @(posedge clk);
    fault_brake <= 1'b1;
    @(posedge clk);
    fault_brake <= 1'b0;
    #1 chk("counter braked", 16'h0000, counter);
    chk("waveforms braked", 16'h0000, {10'h0, pg});
    rd_chk("run cleared", 8'hd7, 8'h20);
    rd_chk("status events", 8'hd9, 8'h0e);
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
